// ===== core/sfe_cfg.svh
/*
  Offsets, field positions, reset values and bus codes of the socket force-event block.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef SFE_CFG_SVH
`define SFE_CFG_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define SFE_ADDR_W 8
`define SFE_OFF_FORCE 8'h0c
`define SFE_OFF_STATUS 8'h40

// ----------------------------------------
// force register fields; bits 15 and 16 are status word fields
// ----------------------------------------
`define SFE_BIT_RETEST 14
`define SFE_BIT_YV 13
`define SFE_BIT_XV 12
`define SFE_BIT_THREE 11
`define SFE_BIT_FIVE 10
`define SFE_BIT_INVALID 9
`define SFE_BIT_LOSS 8
`define SFE_BIT_UNRECOG 7
`define SFE_BIT_CARDBUS 5
`define SFE_BIT_SIXTEEN 4
`define SFE_BIT_POWER_EVT 3
`define SFE_BIT_DET2_EVT 2
`define SFE_BIT_DET1_EVT 1
`define SFE_BIT_STS_EVT 0
`define SFE_BIT_PWR_EN 15
`define SFE_BIT_BUSY 16

// ----------------------------------------
// reset values and bus codes
// ----------------------------------------
`define SFE_FLAGS_RST 9'h000
`define SFE_RESP_OKAY 2'h0
`define SFE_RESP_DECERR 2'h3
`define SFE_ZERO32 32'h0000_0000

`endif

// ===== core/sfe_pkg.sv
/*
  Types shared by the socket force-event block.
  Assumes the configuration header sfe_cfg.svh beside it.
*/
package sfe_pkg;

  typedef enum logic [1:0] {SFE_IDLE, SFE_REQUEST, SFE_WAIT} sfe_retest_state_t;

  // present-state flags held here: caps yv,xv,3v,5v, invalid, loss, unrecog, cardbus, sixteen
  typedef logic [8:0] sfe_flags_t;

endpackage

// ===== core/sfe_links_if.sv
/*
  Carriers between the socket force-event top and its two helpers.
  Assumes one clock domain; the top drives the core side of each.
*/
`timescale 1ns/1ps

interface sfe_regbus_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  modport slave (output wr_en, output wr_addr, output wr_data, output wr_strb, input wr_ok,
                 output rd_en, output rd_addr, input rd_data, input rd_ok);
  modport core (input wr_en, input wr_addr, input wr_data, input wr_strb, output wr_ok,
                input rd_en, input rd_addr, output rd_data, output rd_ok);
endinterface

interface sfe_retest_if;
  logic start;
  logic done;
  logic busy;
  logic req;
  logic capture;
  modport seq (input start, input done, output busy, output req, output capture);
  modport core (output start, output done, input busy, input req, input capture);
endinterface

// ===== core/sfe_axil_slave.sv
/*
  AXI4-Lite slave front end: takes one write and one read at a time and turns them into
  single-cycle strobes on the register carrier.
  Assumes a synchronous active-low reset and a combinational decode on the core side.
*/
`timescale 1ns/1ps
`include "sfe_cfg.svh"

module sfe_axil_slave
  import sfe_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  sfe_regbus_if.slave bus
);

  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write;

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  // address and data may arrive in either order; each is parked until both are here
  assign do_write = !awready && !wready && !bvalid;
  assign bus.wr_en = do_write;
  assign bus.wr_addr = aw_addr_reg;
  assign bus.wr_data = w_data_reg;
  assign bus.wr_strb = w_strb_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // a low ready marks a parked item
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `SFE_RESP_OKAY;
      aw_addr_reg <= 8'h00;
      w_data_reg <= `SFE_ZERO32;
      w_strb_reg <= 4'h0;
    end
    else if (bvalid)
    begin
      if (bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      bresp <= bus.wr_ok ? `SFE_RESP_OKAY : `SFE_RESP_DECERR;
    end
    else
    begin
      if (awready && awvalid)
      begin
        awready <= 1'b0;
        aw_addr_reg <= awaddr;
      end
      if (wready && wvalid)
      begin
        wready <= 1'b0;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  assign bus.rd_en = arready && arvalid;
  assign bus.rd_addr = araddr;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= `SFE_ZERO32;
      rresp <= `SFE_RESP_OKAY;
    end
    else if (rvalid)
    begin
      if (rready)
      begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
    else if (arready && arvalid)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= bus.rd_ok ? bus.rd_data : `SFE_ZERO32;
      rresp <= bus.rd_ok ? `SFE_RESP_OKAY : `SFE_RESP_DECERR;
    end
    else
      arready <= 1'b1;
  end

endmodule // sfe_axil_slave

// ===== core/sfe_retest_seq.sv
/*
  Card re-interrogation sequencer: asks the interrogation logic for a new pass and reports
  when its result may be captured.
  Assumes the interrogation logic answers on the same clock with a done pulse or level.
*/
`timescale 1ns/1ps

module sfe_retest_seq
  import sfe_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  sfe_retest_if.seq rt
);

  sfe_retest_state_t state_reg;

  assign rt.busy = state_reg != SFE_IDLE;
  // result stands only with done; capture must not lag it
  assign rt.capture = (state_reg == SFE_WAIT) && rt.done;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= SFE_IDLE;
      rt.req <= 1'b0;
    end
    else
    begin
      rt.req <= 1'b0;
      unique case (state_reg)
        SFE_IDLE:
        begin
          // a new request while one runs is folded into the running pass
          if (rt.start)
          begin
            state_reg <= SFE_REQUEST;
            rt.req <= 1'b1;
          end
        end
        SFE_REQUEST:
          state_reg <= SFE_WAIT;
        SFE_WAIT:
          if (rt.done)
            state_reg <= SFE_IDLE;
      endcase
    end
  end

endmodule // sfe_retest_seq

// ===== core/sfe_top.sv
/*
  Socket force-event register: software writes it to force socket event bits and held
  present-state flags, override voltage capabilities and start a card re-interrogation.
  Assumes an AXI4-Lite master, neighbouring event, power-control and interrogation logic
  on the same clock, and a global reset pin from outside the clock domain.
*/
// Behaviour
// [R1] force register sits at 0x0c; bits 31 to 15 read as zero
// [R2] writing one to bit 14 re-interrogates card, refreshes flags, re-enables power control
// [R3] software writes bit 14 whenever a forced change needs a card interrogation
// [R4] bit 13 write copies into yv capability flag; one disables power control
// [R5] bit 12 write copies into xv capability flag; one disables power control
// [R6] bit 11 write copies into 3.3 V capability flag; one disables power control
// [R7] bit 10 write copies into 5 V capability flag; one disables power control
// [R8] bit 9 write updates the invalid supply request flag
// [R9] bit 8 write updates the removal data loss flag
// [R10] bit 7 write updates the unrecognized card flag
// [R11] bit 6 is reserved and reads zero
// [R12] bit 5 write updates the cardbus detected flag
// [R13] bit 4 write updates the sixteen bit detected flag
// [R14] bit 3 write sets power event bit; powered status untouched
// [R15] bit 2 write sets detect two event bit; detect two level untouched
// [R16] bit 1 write sets detect one event bit; detect one level untouched
// [R17] bit 0 write sets status change event bit; status change level untouched
// [R18] held flags cleared by global reset; bus reset clears them only without pme; global reset is not seen while aresetn is low
// [R19] writes touch only force targets; write-only positions read with no meaning
`timescale 1ns/1ps
`include "sfe_cfg.svh"

module sfe_top
  import sfe_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic global_reset_n,
  input wire logic pme_enable,
  input wire logic interrogation_done,
  input wire logic [8:0] interrogation_result,
  output logic interrogation_request,
  output logic power_control_enable,
  output logic event_write,
  output logic power_change_event,
  output logic detect_two_event,
  output logic detect_one_event,
  output logic status_change_event,
  output logic yv_capability_flag,
  output logic xv_capability_flag,
  output logic three_volt_capability_flag,
  output logic five_volt_capability_flag,
  output logic invalid_supply_request_flag,
  output logic removal_loss_flag,
  output logic unrecognized_card_flag,
  output logic cardbus_detected_flag,
  output logic sixteen_bit_detected_flag
);

  sfe_regbus_if bus ();
  sfe_retest_if rt ();

  sfe_flags_t flags_reg;
  logic grst_meta_reg;
  logic grst_sync_reg;
  logic lane0_wr;
  logic lane1_wr;
  logic force_wr;
  logic [31:0] wd;
  logic [31:0] status_word;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic reg_hit(input logic [7:0] addr);
    reg_hit = (addr == `SFE_OFF_FORCE) || (addr == `SFE_OFF_STATUS);
  endfunction

  assign bus.wr_ok = reg_hit(bus.wr_addr);
  assign bus.rd_ok = reg_hit(bus.rd_addr);
  assign force_wr = bus.wr_en && (bus.wr_addr == `SFE_OFF_FORCE); // R1
  assign lane0_wr = force_wr && bus.wr_strb[0];
  assign lane1_wr = force_wr && bus.wr_strb[1];
  assign wd = bus.wr_data;

  // ----------------------------------------
  // bus front end and sequencer
  // ----------------------------------------
  sfe_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .bus(bus)
  );

  sfe_retest_seq u_retest (
    .aclk(aclk),
    .aresetn(aresetn),
    .rt(rt)
  );

  assign rt.start = lane1_wr && wd[`SFE_BIT_RETEST]; // R2
  assign rt.done = interrogation_done;
  assign interrogation_request = rt.req;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // the force register reads zero throughout: its write-only bits carry no state worth
  // showing, and the held flags are visible in the status word instead
  always_comb
  begin
    status_word = `SFE_ZERO32;
    status_word[`SFE_BIT_YV:`SFE_BIT_UNRECOG] = flags_reg[8:2];
    status_word[`SFE_BIT_CARDBUS:`SFE_BIT_SIXTEEN] = flags_reg[1:0];
    status_word[`SFE_BIT_PWR_EN] = power_control_enable;
    status_word[`SFE_BIT_BUSY] = rt.busy;
  end

  assign bus.rd_data = (bus.rd_addr == `SFE_OFF_STATUS) ? status_word : `SFE_ZERO32; // R1 R11 R19

  // ----------------------------------------
  // global reset synchroniser
  // ----------------------------------------
  // the pin is asynchronous to aclk; flags only see the second stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      grst_meta_reg <= 1'b1;
      grst_sync_reg <= 1'b1;
    end
    else
    begin
      grst_meta_reg <= global_reset_n;
      grst_sync_reg <= grst_meta_reg;
    end
  end

  // ----------------------------------------
  // held present-state flags
  // ----------------------------------------
  // a finished interrogation wins over a force write in the same cycle, since it carries
  // the newer view of the card
  always_ff @(posedge aclk)
  begin
    if (!grst_sync_reg)
      flags_reg <= `SFE_FLAGS_RST; // R18
    else if (!aresetn && !pme_enable)
      flags_reg <= `SFE_FLAGS_RST; // R18
    else if (!aresetn)
      flags_reg <= flags_reg; // R18
    else if (rt.capture)
      flags_reg <= interrogation_result; // R2
    else
    begin
      if (lane1_wr)
      begin
        flags_reg[8] <= wd[`SFE_BIT_YV]; // R4
        flags_reg[7] <= wd[`SFE_BIT_XV]; // R5
        flags_reg[6] <= wd[`SFE_BIT_THREE]; // R6
        flags_reg[5] <= wd[`SFE_BIT_FIVE]; // R7
        flags_reg[4] <= wd[`SFE_BIT_INVALID]; // R8
        flags_reg[3] <= wd[`SFE_BIT_LOSS]; // R9
      end
      if (lane0_wr)
      begin
        flags_reg[2] <= wd[`SFE_BIT_UNRECOG]; // R10
        flags_reg[1] <= wd[`SFE_BIT_CARDBUS]; // R12
        flags_reg[0] <= wd[`SFE_BIT_SIXTEEN]; // R13
      end
    end
  end

  assign yv_capability_flag = flags_reg[8];
  assign xv_capability_flag = flags_reg[7];
  assign three_volt_capability_flag = flags_reg[6];
  assign five_volt_capability_flag = flags_reg[5];
  assign invalid_supply_request_flag = flags_reg[4];
  assign removal_loss_flag = flags_reg[3];
  assign unrecognized_card_flag = flags_reg[2];
  assign cardbus_detected_flag = flags_reg[1];
  assign sixteen_bit_detected_flag = flags_reg[0];

  // ----------------------------------------
  // socket power control enable
  // ----------------------------------------
  // a forced capability disables power control until a re-interrogation completes; a write
  // that forces and retests at once ends enabled only after the new pass
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      power_control_enable <= 1'b1;
    else if (lane1_wr && (wd[`SFE_BIT_YV:`SFE_BIT_FIVE] != 4'h0))
      power_control_enable <= 1'b0; // R4 R5 R6 R7
    else if (rt.capture)
      power_control_enable <= 1'b1; // R2
  end

  // ----------------------------------------
  // socket event forcing
  // ----------------------------------------
  // only the event bits move; the live level bits belong to the neighbour and get nothing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      event_write <= 1'b0;
      power_change_event <= 1'b0;
      detect_two_event <= 1'b0;
      detect_one_event <= 1'b0;
      status_change_event <= 1'b0;
    end
    else
    begin
      event_write <= lane0_wr; // R19
      if (lane0_wr)
      begin
        power_change_event <= wd[`SFE_BIT_POWER_EVT]; // R14
        detect_two_event <= wd[`SFE_BIT_DET2_EVT]; // R15
        detect_one_event <= wd[`SFE_BIT_DET1_EVT]; // R16
        status_change_event <= wd[`SFE_BIT_STS_EVT]; // R17
      end
    end
  end

endmodule // sfe_top

// ===== testbench/sfe_top_props.sv
/*
  Port checker of the socket force-event top.
  Assumes one clock domain; the bench binds it onto the design.
*/
`timescale 1ns/1ps

module sfe_top_props
  import sfe_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic global_reset_n,
  input wire logic pme_enable,
  input wire logic interrogation_done,
  input wire logic [8:0] interrogation_result,
  input wire logic interrogation_request,
  input wire logic power_control_enable,
  input wire logic event_write,
  input wire logic power_change_event,
  input wire logic detect_two_event,
  input wire logic detect_one_event,
  input wire logic status_change_event,
  input wire logic yv_capability_flag,
  input wire logic xv_capability_flag,
  input wire logic three_volt_capability_flag,
  input wire logic five_volt_capability_flag,
  input wire logic invalid_supply_request_flag,
  input wire logic removal_loss_flag,
  input wire logic unrecognized_card_flag,
  input wire logic cardbus_detected_flag,
  input wire logic sixteen_bit_detected_flag
);
  // ----------------------------------------
  // captured request fields
  // ----------------------------------------
  logic [7:0] aw_reg;
  logic [7:0] ar_reg;
  logic [31:0] wd_reg;
  logic [3:0] ws_reg;
  logic pend_reg;
  sfe_flags_t hold_reg;
  wire sfe_flags_t fl = {yv_capability_flag, xv_capability_flag, three_volt_capability_flag,
    five_volt_capability_flag, invalid_supply_request_flag, removal_loss_flag, unrecognized_card_flag,
    cardbus_detected_flag, sixteen_bit_detected_flag};
  // a pending capture outranks a force write, so such writes are not judged
  wire logic hit = aw_reg == 8'h0c && global_reset_n && !pend_reg;

  always_ff @(posedge aclk)
  begin
    if (s_axi_awvalid && s_axi_awready) aw_reg <= s_axi_awaddr;
    if (s_axi_arvalid && s_axi_arready) ar_reg <= s_axi_araddr;
    if (s_axi_wvalid && s_axi_wready) {ws_reg, wd_reg} <= {s_axi_wstrb, s_axi_wdata};
    if (aresetn) hold_reg <= fl;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || interrogation_done) pend_reg <= 1'b0;
    else if (interrogation_request) pend_reg <= 1'b1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("late write response");
  a_force_reads_zero: assert property (s_axi_rvalid && ar_reg == 8'h0c
    |-> s_axi_rdata == 32'h0000_0000 && s_axi_rresp == 2'h0) else $error("force read not zero");
  a_unmapped_decerr: assert property ($rose(s_axi_bvalid) && aw_reg != 8'h0c && aw_reg != 8'h40
    |-> s_axi_bresp == 2'h3) else $error("unmapped write not refused");
  a_lane0_copy: assert property ($rose(s_axi_bvalid) && hit && ws_reg[0]
    |-> event_write && {power_change_event, detect_two_event, detect_one_event, status_change_event} == wd_reg[3:0]
    && fl[2:0] == {wd_reg[7], wd_reg[5], wd_reg[4]}) else $error("lane 0 force lost");
  a_lane1_copy: assert property ($rose(s_axi_bvalid) && hit && ws_reg[1]
    |-> fl[8:3] == wd_reg[13:8]) else $error("lane 1 force lost");
  a_power_off: assert property ($rose(s_axi_bvalid) && hit && ws_reg[1] && |wd_reg[13:10]
    |-> !power_control_enable) else $error("power control still enabled");
  a_retest_start: assert property ($rose(s_axi_bvalid) && hit && ws_reg[1] && wd_reg[14]
    |-> interrogation_request) else $error("interrogation not requested");
  a_capture_result: assert property (pend_reg && interrogation_done
    |=> power_control_enable && fl == $past(interrogation_result)) else $error("result not captured");
  a_pme_context: assert property (aresetn && !$past(aresetn)
    |-> fl == (pme_enable ? hold_reg : 9'h000)) else $error("flags wrong after bus reset");
  a_global_clear: assert property (!global_reset_n [*4] |-> fl == 9'h000)
    else $error("flags not cleared by global reset");
endmodule // sfe_top_props

// ===== testbench/sfe_interrogation_model.sv
/*
  Card interrogation responder beside the force-event block.
  Assumes a one-cycle request pulse on aclk; slow selects the longer answer.
*/
`timescale 1ns/1ps

module sfe_interrogation_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic interrogation_request,
  input wire logic slow,
  input wire logic [8:0] value,
  output logic interrogation_done,
  output logic [8:0] interrogation_result
);
  // ----------------------------------------
  // answer timing
  // ----------------------------------------
  logic [3:0] cnt_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_reg <= 4'h0;
      interrogation_done <= 1'b0;
      interrogation_result <= 9'h000;
    end
    else
    begin
      if (interrogation_request) cnt_reg <= slow ? 4'h9 : 4'h3;
      else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
      interrogation_done <= cnt_reg == 4'h1;
      // result means nothing outside the done cycle, so it keeps toggling there
      interrogation_result <= (cnt_reg == 4'h1) ? value : ~interrogation_result;
    end
  end
endmodule // sfe_interrogation_model

// ===== testbench/tb.sv
/*
  Self-checking bench of the socket force-event top.
  Assumes the interrogation responder model and the checker bound below.
*/
`timescale 1ns/1ps

module tb
  import sfe_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic global_reset_n = 1'b1;
  logic pme_enable = 1'b0;
  logic slow = 1'b0;
  logic [8:0] value = 9'h000;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, interrogation_done;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [8:0] interrogation_result;
  logic interrogation_request, power_control_enable, event_write;
  logic power_change_event, detect_two_event, detect_one_event, status_change_event;
  logic yv_capability_flag, xv_capability_flag, three_volt_capability_flag, five_volt_capability_flag;
  logic invalid_supply_request_flag, removal_loss_flag, unrecognized_card_flag;
  logic cardbus_detected_flag, sixteen_bit_detected_flag;
  wire sfe_flags_t fl = {yv_capability_flag, xv_capability_flag, three_volt_capability_flag,
    five_volt_capability_flag, invalid_supply_request_flag, removal_loss_flag, unrecognized_card_flag,
    cardbus_detected_flag, sixteen_bit_detected_flag};
  wire logic [3:0] ev = {power_change_event, detect_two_event, detect_one_event, status_change_event};
  int seed = 4;
  int fail_count = 0;
  int comparisons = 0;
  sfe_flags_t ef = 9'h000;
  logic pe = 1'b1;

  sfe_top i_sfe_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .global_reset_n,
    .pme_enable, .interrogation_done, .interrogation_result, .interrogation_request, .power_control_enable,
    .event_write, .power_change_event, .detect_two_event, .detect_one_event, .status_change_event,
    .yv_capability_flag, .xv_capability_flag, .three_volt_capability_flag, .five_volt_capability_flag,
    .invalid_supply_request_flag, .removal_loss_flag, .unrecognized_card_flag, .cardbus_detected_flag,
    .sixteen_bit_detected_flag);
  sfe_interrogation_model i_sfe_interrogation_model (.aclk, .aresetn, .interrogation_request, .slow, .value,
    .interrogation_done, .interrogation_result);

  always #2.5 aclk = ~aclk;

  // ----------------------------------------
  // expectations, bus cycles and checks
  // ----------------------------------------
  function automatic sfe_flags_t nf(sfe_flags_t f, logic [31:0] d, logic [3:0] s);
    nf = f;
    if (s[1]) nf[8:3] = d[13:8];
    if (s[0]) nf[2:0] = {d[7], d[5], d[4]};
  endfunction

  function automatic logic [31:0] st(sfe_flags_t f, logic p);
    st = {16'h0000, p, 1'b0, f[8:2], 1'b0, f[1:0], 4'h0};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // each channel holds until its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [31:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk({30'h0, s_axi_rresp}, er);
  endtask

  task automatic rst(input logic p);
    @(posedge aclk);
    pme_enable <= p;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
  endtask

  initial
  begin
    logic [31:0] d;
    logic [3:0] s;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h0c, 32'h0000_0000, 0);
    rd(8'h40, st(ef, pe), 0);
    for (int i = 0; i < 40; i++)
    begin
      d = (i == 0) ? 32'hffff_bfff : (i == 1) ? 32'h0000_0000 : $random(seed) & 32'hffff_bfff;
      s = (i < 2) ? 4'hf : 4'($random(seed));
      wr(8'h0c, d, s, 0);
      ef = nf(ef, d, s);
      if (s[1] && |d[13:10]) pe = 1'b0;
      chk(32'(fl), 32'(ef));
      chk(32'(power_control_enable), 32'(pe));
      chk(32'(event_write), 32'(s[0]));
      if (s[0]) chk(32'(ev), 32'(d[3:0]));
      rd(8'h40, st(ef, pe), 0);
    end
    for (int k = 0; k < 2; k++)
    begin
      @(posedge aclk);
      slow <= k[0];
      value <= 9'($random(seed));
      wr(8'h0c, 32'h0000_4c00, 4'h2, 0);
      chk(32'(power_control_enable), 0);
      @(posedge aclk iff interrogation_done === 1'b1);
      #1;
      ef = value;
      pe = 1'b1;
      chk(32'(fl), 32'(ef));
      chk(32'(power_control_enable), 1);
    end
    wr(8'h24, 32'hffff_ffff, 4'hf, 3);
    chk(32'(fl), 32'(ef));
    chk(32'(event_write), 0);
    rd(8'h24, 32'h0000_0000, 3);
    for (int p = 1; p >= 0; p--)
    begin
      wr(8'h0c, 32'h0000_23b0, 4'h3, 0);
      ef = nf(ef, 32'h0000_23b0, 4'h3);
      rst(p[0]);
      if (p == 0) ef = 9'h000;
      chk(32'(fl), 32'(ef));
      chk(32'(power_control_enable), 1);
      pe = 1'b1;
    end
    wr(8'h0c, 32'h0000_03b0, 4'h3, 0);
    global_reset_n <= 1'b0;
    repeat (6) @(posedge aclk);
    global_reset_n <= 1'b1;
    repeat (4) @(posedge aclk);
    #1;
    chk(32'(fl), 0);
    chk(32'(power_control_enable), 32'(pe));
    end_of_test();
  end

  // about 25 times the expected run length
  initial
  begin
    #50000;
    fail_count++;
    end_of_test();
  end
endmodule // tb

bind sfe_top sfe_top_props i_sfe_top_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .global_reset_n, .pme_enable,
  .interrogation_done, .interrogation_result, .interrogation_request, .power_control_enable, .event_write,
  .power_change_event, .detect_two_event, .detect_one_event, .status_change_event, .yv_capability_flag,
  .xv_capability_flag, .three_volt_capability_flag, .five_volt_capability_flag, .invalid_supply_request_flag,
  .removal_loss_flag, .unrecognized_card_flag, .cardbus_detected_flag, .sixteen_bit_detected_flag);
